// File: rtl/pec_pkg.sv
/*
  Package for the second extended control and status register block.
  Holds the register address, field positions, reset values, and the MDIO
  frame constants. Assumes a single 100 MHz clock domain for all users.
*/
package pec_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] PEC_REG_ADDR = 5'h13;   // Extended control two
  localparam logic [15:0] PEC_RESET_LOW = 16'h0001; // Bits 13:0 default
  localparam logic [15:0] PEC_RW_MASK = 16'h1BFF;  // Writable bits
  localparam int PEC_BIT_NODE = 15;   // Node or repeater strap
  localparam int PEC_BIT_SWPRI = 14;  // Hardware or software priority
  localparam int PEC_BIT_RFLT = 13;   // Remote fault mirror
  localparam int PEC_BIT_FLOAT = 7;   // Line driver float enable
  localparam int PEC_BIT_APD = 0;     // Automatic 100M power down

  // ****************************************************************
  // MDIO frame constants
  // ****************************************************************
  localparam logic [1:0] PEC_ST = 2'h1;      // Start of frame
  localparam logic [1:0] PEC_OP_RD = 2'h2;   // Read opcode
  localparam logic [1:0] PEC_OP_WR = 2'h1;   // Write opcode
  localparam logic [5:0] PEC_PRE_MIN = 6'h20; // Preamble ones needed
  localparam logic [5:0] PEC_HDR_BITS = 6'h0E; // ST..REGAD bits
  localparam logic [5:0] PEC_TA_BITS = 6'h02;  // Turnaround bits
  localparam logic [5:0] PEC_DAT_BITS = 6'h10; // Data bits

  // Control outputs travelling together to the line interface
  typedef struct packed {
    logic line_driver_float_enable; // Transmit drivers float
    logic tx100_power_down;         // 100M transceiver off
    logic heartbeat_test;           // Collision heartbeat enabled
    logic crs_on_tx;                // Carrier sense on transmit too
    logic sw_priority;              // Register bits govern config
  } pec_ctrl_s;
endpackage

// File: rtl/pec_ext_ctrl2.sv
/*
  Second extended control and status register, reached by an MDIO slave.
  Assumes MDC is much slower than clk; MDC and MDIO pass synchronisers.
*/
// Summary of operation
// [R1] Management writes reserved bits with defaults
// [R2] Bit 15 reports node or repeater
// [R3] Bits 15,14 reset to sampled straps
// [R4] Node mode: heartbeat on, carrier sense both
// [R5] Bit 14 reports hardware or software priority
// [R6] Bit 13 mirrors partner remote fault
// [R7] Bit 7 floats both transmit outputs
// [R8] Bit 0 with 10M powers down 100M
// [R9] Bit 0 clear: no automatic power down
// [R10] Isolate also powers down 100M transceiver
// [R11] Reserved bits reset zero, bit 10 read-only
// [R12] Speed indicator high at 100M
// [R13] Active low reset restores defaults
// [R14] MDIO frames at address 0x13, 16 bits
`timescale 1ns/1ps
`default_nettype none
module pec_ext_ctrl2 #(
  parameter logic [4:0] PHY_ADDR = 5'h00  // Station address, plain default
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic node_repeater_strap,
  input wire logic sw_priority_strap,
  input wire logic partner_remote_fault,
  input wire logic speed_100,
  input wire logic isolate,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic speed_ind,
  output logic line_tx_pos,
  output logic line_tx_neg,
  output logic line_tx_pos_oe,
  output logic line_tx_neg_oe,
  input wire logic tx_pos_data,
  input wire logic tx_neg_data,
  output var pec_pkg::pec_ctrl_s ctrl
);
  // Checks below sample on clk; all but rst_def_a rest while reset is held
  default clocking pec_cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] mdc_s_r;  // MDC sampling chain
  logic [2:0] mdi_s_r;  // MDIO sampling chain
  logic mdc_lvl_r;      // Accepted MDC level
  logic mdi_lvl_r;      // Accepted MDIO level

  // Three stages; a change counts when stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mdc_s_r <= 3'h0;
      mdi_s_r <= 3'h7; // Idle line level, so no false zero after reset
      mdc_lvl_r <= 1'b0;
      mdi_lvl_r <= 1'b1;
    end else begin
      mdc_s_r <= {mdc_s_r[1:0], mdc};
      mdi_s_r <= {mdi_s_r[1:0], mdio_in};
      if (mdc_s_r[1] == mdc_s_r[2]) begin
        mdc_lvl_r <= mdc_s_r[2];
      end
      if (mdi_s_r[1] == mdi_s_r[2]) begin
        mdi_lvl_r <= mdi_s_r[2];
      end
    end
  end

  logic mdc_rise;
  logic mdc_fall;
  assign mdc_rise = (mdc_s_r[1] == mdc_s_r[2]) && mdc_s_r[2] && !mdc_lvl_r;
  assign mdc_fall = (mdc_s_r[1] == mdc_s_r[2]) && !mdc_s_r[2] && mdc_lvl_r;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic node_r;   // Strapped node or repeater
  logic swpri_r;  // Strapped priority
  logic [13:0] low_r; // Bits 13:0; bit 13 is status, rebuilt on read
  logic strap_done_r; // Straps caught after release
  logic wr_pulse;
  logic [15:0] wr_data_r;
  logic [15:0] rd_word;

  // Straps are caught on the first clock after reset is released [R3]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
      node_r <= 1'b0;
      swpri_r <= 1'b1;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      node_r <= node_repeater_strap; // [R3]
      swpri_r <= sw_priority_strap;  // [R3]
    end
  end

  // Writable bits; reserved ones reset to zero and bit 10 is kept [R11]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_r <= pec_pkg::PEC_RESET_LOW[13:0]; // [R13] [R11]
    end else if (wr_pulse) begin
      // Software is trusted to write reserved defaults back [R1]
      low_r <= (wr_data_r[13:0] & pec_pkg::PEC_RW_MASK[13:0]) |
               (low_r & ~pec_pkg::PEC_RW_MASK[13:0]); // [R11]
    end
  end
  ro_bit10_a: assert property (wr_pulse |=> $stable(low_r[10])) // [R11]
    else $error("bit 10 written");
  rst_def_a: assert property (disable iff (1'b0) // [R13]
    !rst_n |=> low_r == pec_pkg::PEC_RESET_LOW[13:0])
    else $error("reset defaults wrong");

  // Read word: bit 13 tracks its source live, bits 15:14 hold the caught straps [R2] [R5] [R6]
  always_comb begin
    rd_word = {node_r, swpri_r, partner_remote_fault, low_r[12:0]};
  end
  node_rd_a: assert property ($rose(strap_done_r) |-> rd_word[15:14] == // [R2]
    {$past(node_repeater_strap), $past(sw_priority_strap)})
    else $error("strap bits misreported");

  // ****************************************************************
  // MDIO slave
  // ****************************************************************
  typedef enum {PEC_IDLE, PEC_HDR, PEC_TA, PEC_RDAT, PEC_WDAT} pec_st_e;
  pec_st_e st_r;
  logic [5:0] cnt_r;      // Bit counter within a phase
  logic [13:0] hdr_r;     // ST, OP, PHYAD, REGAD
  logic [15:0] sh_r;      // Read shift register
  logic hit;
  logic [1:0] op_fld;
  assign op_fld = hdr_r[11:10];
  assign hit = (hdr_r[13:12] == pec_pkg::PEC_ST) &&
               (hdr_r[9:5] == PHY_ADDR) &&
               (hdr_r[4:0] == pec_pkg::PEC_REG_ADDR); // [R14]

  // Frame sequencer, sampling on MDC rise and driving on MDC fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= PEC_IDLE;
      cnt_r <= 6'h00;
      hdr_r <= 14'h0000;
      wr_data_r <= 16'h0000;
      sh_r <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      wr_pulse <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      case (st_r)
        PEC_IDLE: begin
          // Count preamble ones, then wait for the first zero of ST
          if (mdc_rise) begin
            if (mdi_lvl_r) begin
              if (cnt_r != pec_pkg::PEC_PRE_MIN) begin
                cnt_r <= cnt_r + 6'h01;
              end
            end else if (cnt_r == pec_pkg::PEC_PRE_MIN) begin
              hdr_r <= 14'h0000;
              cnt_r <= 6'h01;
              st_r <= PEC_HDR;
            end else begin
              cnt_r <= 6'h00;
            end
          end
        end
        PEC_HDR: begin
          if (mdc_rise) begin
            hdr_r <= {hdr_r[12:0], mdi_lvl_r};
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == pec_pkg::PEC_HDR_BITS - 6'h01) begin
              cnt_r <= 6'h00;
              st_r <= PEC_TA;
            end
          end
        end
        PEC_TA: begin
          // Frames for other addresses are ignored, line left released
          if (!hit) begin
            st_r <= PEC_IDLE;
            cnt_r <= 6'h00;
          end else if (op_fld == pec_pkg::PEC_OP_RD) begin
            sh_r <= rd_word;
            if (mdc_fall) begin
              cnt_r <= cnt_r + 6'h01;
              if (cnt_r == pec_pkg::PEC_TA_BITS - 6'h01) begin
                // Second turnaround bit driven low
                mdio_oe <= 1'b1;
                mdio_out <= 1'b0;
                cnt_r <= 6'h00;
                st_r <= PEC_RDAT;
              end
            end
          end else if (op_fld == pec_pkg::PEC_OP_WR) begin
            if (mdc_rise) begin
              cnt_r <= cnt_r + 6'h01;
              if (cnt_r == pec_pkg::PEC_TA_BITS - 6'h01) begin
                cnt_r <= 6'h00;
                st_r <= PEC_WDAT;
              end
            end
          end else begin
            st_r <= PEC_IDLE;
            cnt_r <= 6'h00;
          end
        end
        PEC_RDAT: begin
          // Most significant bit first; line released after bit 0
          if (mdc_fall) begin
            if (cnt_r == pec_pkg::PEC_DAT_BITS) begin
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
              cnt_r <= 6'h00;
              st_r <= PEC_IDLE;
            end else begin
              mdio_out <= sh_r[15];
              sh_r <= {sh_r[14:0], 1'b0};
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        PEC_WDAT: begin
          if (mdc_rise) begin
            wr_data_r <= {wr_data_r[14:0], mdi_lvl_r};
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == pec_pkg::PEC_DAT_BITS - 6'h01) begin
              wr_pulse <= 1'b1; // [R14]
              cnt_r <= 6'h00;
              st_r <= PEC_IDLE;
            end
          end
        end
        default: begin
          st_r <= PEC_IDLE;
          cnt_r <= 6'h00;
        end
      endcase
    end
  end
  rflt_rd_a: assert property (st_r == PEC_TA && hit && // [R6]
    op_fld == pec_pkg::PEC_OP_RD |=> sh_r[13] == $past(partner_remote_fault))
    else $error("remote fault not mirrored");

  // ****************************************************************
  // Control outputs
  // ****************************************************************
  // Registered so the line interface never sees a glitch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= '0;
      speed_ind <= 1'b0;
    end else begin
      ctrl.line_driver_float_enable <= low_r[pec_pkg::PEC_BIT_FLOAT]; // [R7]
      // Auto power down only at 10M; isolate forces it [R8] [R9] [R10]
      ctrl.tx100_power_down <= (low_r[pec_pkg::PEC_BIT_APD] && !speed_100)
                               || isolate;
      ctrl.heartbeat_test <= !node_r; // [R4]
      ctrl.crs_on_tx <= !node_r;      // [R4]
      ctrl.sw_priority <= swpri_r;    // [R5]
      speed_ind <= speed_100;         // [R12]
    end
  end
  apd_on_a: assert property (rst_n && low_r[0] && !speed_100 |=> // [R8]
    ctrl.tx100_power_down) else $error("no auto power down at 10M");
  apd_off_a: assert property (rst_n && !low_r[0] && !isolate |=> // [R9]
    !ctrl.tx100_power_down) else $error("unexpected power down");
  iso_pd_a: assert property (rst_n && isolate |=> // [R10]
    ctrl.tx100_power_down) else $error("isolate did not power down");
  speed_out_a: assert property ($past(rst_n) |-> // [R12]
    speed_ind == $past(speed_100)) else $error("speed indicator wrong");
  node_hb_a: assert property (rst_n && !node_r ##1 !node_r |-> // [R4]
    ctrl.heartbeat_test && ctrl.crs_on_tx)
    else $error("node defaults missing");

  // Transmit pair drivers; enables drop while floated [R7]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
    end else begin
      line_tx_pos <= tx_pos_data;
      line_tx_neg <= tx_neg_data;
    end
  end
  assign line_tx_pos_oe = !ctrl.line_driver_float_enable; // [R7]
  assign line_tx_neg_oe = !ctrl.line_driver_float_enable; // [R7]
  float_oe_a: assert property (rst_n && low_r[7] |=> // [R7]
    !line_tx_pos_oe && !line_tx_neg_oe) else $error("drivers not floated");
endmodule
`default_nettype wire

// File: testbench/pec_mdio_mgr.sv
/*
  Station manager model: sends MDIO frames with an 80 ns MDC.
  Assumes the bench resolves the shared line with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module pec_mdio_mgr (
  input wire logic clk,
  input wire logic mdio_line,
  output logic mdc,
  output logic mgr_out,
  output logic mgr_oe
);
  // ****************************************
  // Frame engine
  // ****************************************
  // MDC stands low between frames
  initial begin
    mdc = 1'b0;
    mgr_out = 1'b0;
    mgr_oe = 1'b0;
  end

  // One bit: change after the fall, hold across the rise
  task automatic put(input logic b);
    mgr_out = b;
    mgr_oe = 1'b1;
    #40 mdc = 1'b1;
    #40 mdc = 1'b0;
  endtask

  // Whole frame at station address 0; reads sample late in the high
  // phase since the device answers a few clocks after each fall
  task automatic frame(input logic [1:0] op, input logic [4:0] reg_a,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    int i;
    f = {32'hFFFFFFFF, pec_pkg::PEC_ST, op, 5'h00, reg_a, 2'h2, wd};
    rd = 16'hFFFF;
    @(posedge clk);
    #3;
    for (i = 63; i >= 0; i--) begin
      if (op == pec_pkg::PEC_OP_RD && i < 18) begin
        mgr_oe = 1'b0; // Turnaround and data belong to the device
        #40 mdc = 1'b1;
        #35 rd = {rd[14:0], mdio_line};
        #5 mdc = 1'b0;
      end else begin
        put(f[i]);
      end
    end
    mgr_oe = 1'b0; // Released line returns to the pull-up
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_phy_extended_control_two.sv
/*
  Bench for the second extended control register: MDIO frames via
  the manager model, straps and line controls driven from here.
  Assumes the design's default station address.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_phy_extended_control_two;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic node_s = 1'b1; // Repeater strap first
  logic sw_s = 1'b0;
  logic rflt = 1'b0;
  logic spd = 1'b0;
  logic iso = 1'b0;
  logic txp = 1'b1;
  logic txn = 1'b0;
  logic mdc, mdio_out, mdio_oe, mgr_out, mgr_oe, mdio_line;
  logic speed_ind, lp, ln, lp_oe, ln_oe;
  pec_pkg::pec_ctrl_s ctrl;
  logic [15:0] rd;
  logic [4:0] ra = pec_pkg::PEC_REG_ADDR;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int k;

  always #5 clk = ~clk;
  // Pull-up on the management line when nobody drives
  assign mdio_line = mdio_oe ? mdio_out : (mgr_oe ? mgr_out : 1'b1);

  pec_ext_ctrl2 uut (.clk(clk), .rst_n(rst_n),
    .node_repeater_strap(node_s), .sw_priority_strap(sw_s),
    .partner_remote_fault(rflt), .speed_100(spd), .isolate(iso),
    .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .speed_ind(speed_ind), .line_tx_pos(lp),
    .line_tx_neg(ln), .line_tx_pos_oe(lp_oe), .line_tx_neg_oe(ln_oe),
    .tx_pos_data(txp), .tx_neg_data(txn), .ctrl(ctrl));
  pec_mdio_mgr mgr (.clk(clk), .mdio_line(mdio_line), .mdc(mdc),
    .mgr_out(mgr_out), .mgr_oe(mgr_oe));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic rd_reg(input logic [4:0] a);
    mgr.frame(pec_pkg::PEC_OP_RD, a, 16'h0000, rd);
    @(posedge clk); // Later stimulus then changes on a clock edge
  endtask

  // Register lands a few clocks after the last data rise
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    mgr.frame(pec_pkg::PEC_OP_WR, a, d, rd);
    repeat (10) @(posedge clk);
  endtask

  // Straps must be settled before the release
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    check("line oe in reset", 16'({lp_oe, ln_oe}), 16'h0003);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  // Hang guard, nearly three times the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    do_reset();
    rd_reg(ra);
    check("reset word", rd, 16'h8001);
    check("mode ctrl", 16'({ctrl.heartbeat_test, ctrl.crs_on_tx,
      ctrl.sw_priority}), 16'h0000);
    rflt <= 1'b1;
    rd_reg(ra);
    check("remote fault", rd, 16'hA001);
    rflt <= 1'b0;
    // Read-only bits written as ones must not stick
    wr_reg(ra, 16'hE080);
    rd_reg(ra);
    check("float word", rd, 16'h8080);
    check("float oe", 16'({lp_oe, ln_oe}), 16'h0000);
    wr_reg(ra, 16'h0000);
    txp <= 1'b0;
    txn <= 1'b1;
    repeat (3) @(posedge clk);
    check("line data", 16'({lp_oe, ln_oe, lp, ln}), 16'h000D);
    // Frames for another register are ignored
    wr_reg(5'h12, 16'h0081);
    rd_reg(ra);
    check("other addr", rd, 16'h8000);
    rd_reg(5'h12);
    check("undriven read", rd, 16'hFFFF);
    // Unknown opcodes leave the register and the line alone
    mgr.frame(2'h3, ra, 16'hFFFF, rd);
    rd_reg(ra);
    check("bad opcode", rd, 16'h8000);
    // Every mix of auto power down, speed and isolate
    for (k = 0; k < 8; k++) begin
      if (k % 4 == 0) begin
        wr_reg(ra, {15'h0000, k[2]});
      end
      spd <= k[1];
      iso <= k[0];
      repeat (3) @(posedge clk);
      check("power down", 16'(ctrl.tx100_power_down),
        16'((k[2] & ~k[1]) | k[0]));
      check("speed ind", 16'(speed_ind), 16'(k[1]));
    end
    // Second reset in node, software mode restores defaults
    wr_reg(ra, 16'h0080);
    node_s <= 1'b0;
    sw_s <= 1'b1;
    do_reset();
    rd_reg(ra);
    check("node word", rd, 16'h4001);
    check("node ctrl", 16'({ctrl.heartbeat_test, ctrl.crs_on_tx,
      ctrl.sw_priority}), 16'h0007);
    stop_test();
  end
endmodule
`default_nettype wire
